/* bmu_pkg.sv */
// Shared constants and types for the bit manipulation unit
package bmu_pkg;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] BMU_OFF_DEST = 8'h00;
  localparam logic [7:0] BMU_OFF_SRC = 8'h04;
  localparam logic [7:0] BMU_OFF_CTRL = 8'h08;
  localparam logic [7:0] BMU_OFF_FLAGS = 8'h0c;
  localparam logic [7:0] BMU_OFF_STATUS = 8'h10;

  // Control word field positions
  localparam int unsigned BMU_CTRL_OP_LSB = 0;
  localparam int unsigned BMU_CTRL_OP_W = 4;
  localparam int unsigned BMU_CTRL_WIDE_BIT = 4;
  localparam int unsigned BMU_CTRL_CNT_LSB = 8;
  localparam int unsigned BMU_CTRL_CNT_W = 5;
  localparam int unsigned BMU_CTRL_CC_LSB = 16;
  localparam int unsigned BMU_CTRL_CC_W = 4;

  // Flag word bit positions
  localparam int unsigned BMU_FLG_CARRY = 0;
  localparam int unsigned BMU_FLG_OVERFLOW = 1;
  localparam int unsigned BMU_FLG_SIGN = 2;
  localparam int unsigned BMU_FLG_ZERO = 3;
  localparam int unsigned BMU_FLG_PARITY = 4;

  // Status word bit positions
  localparam int unsigned BMU_STS_NO_BIT = 0;

  // Reset values
  localparam logic [31:0] BMU_RST_WORD = 32'h0000_0000;
  localparam logic BMU_RST_FLAG = 1'b0;

  // Base conditions; low bit of the code inverts the test
  localparam logic [2:0] BMU_CC_OVERFLOW = 3'h0;
  localparam logic [2:0] BMU_CC_CARRY = 3'h1;
  localparam logic [2:0] BMU_CC_ZERO = 3'h2;
  localparam logic [2:0] BMU_CC_CARRY_OR_ZERO = 3'h3;
  localparam logic [2:0] BMU_CC_SIGN = 3'h4;
  localparam logic [2:0] BMU_CC_PARITY = 3'h5;
  localparam logic [2:0] BMU_CC_LESS = 3'h6;
  localparam logic [2:0] BMU_CC_LESS_EQUAL = 3'h7;

  // Operation select
  typedef enum logic [3:0] {
    BMU_OP_DOUBLE_SHIFT_LEFT,
    BMU_OP_DOUBLE_SHIFT_RIGHT,
    BMU_OP_ROTATE_LEFT_PLAIN,
    BMU_OP_ROTATE_RIGHT_PLAIN,
    BMU_OP_ROTATE_LEFT_VIA_CARRY,
    BMU_OP_ROTATE_RIGHT_VIA_CARRY,
    BMU_OP_BIT_PROBE,
    BMU_OP_BIT_PROBE_AND_FORCE_ONE,
    BMU_OP_BIT_PROBE_AND_FORCE_ZERO,
    BMU_OP_BIT_PROBE_AND_INVERT,
    BMU_OP_SCAN_UP_FIRST_ONE,
    BMU_OP_SCAN_DOWN_FIRST_ONE,
    BMU_OP_SET_BYTE_ON_CONDITION,
    BMU_OP_AND_TEST
  } bmu_op_t;

  // Whole state of the unit
  typedef struct packed {
    logic [31:0] dest;
    logic [31:0] src;
    logic [31:0] ctrl;
    logic carry_flag;
    logic overflow_flag;
    logic sign_flag;
    logic zero_flag;
    logic parity_flag;
    logic no_bit_found;
    logic [31:0] rdata;
  } bmu_state_t;

endpackage

/* bmu_bit_scan.sv */
// First set bit finder, upward or downward, for 16 or 32 bit operands
`timescale 1ns/1ps
module bmu_bit_scan #(
  parameter bit SCAN_DOWN = 1'b0
) (
  input wire logic [31:0] vec_in,
  input wire logic wide_in,
  output logic [4:0] index_out,
  output logic found_out
);

  logic [31:0] vec_m;

  // Narrow operands ignore the upper half
  assign vec_m = wide_in ? vec_in : {16'h0000, vec_in[15:0]};

  // Priority search; the last hit in loop order wins
  always_comb begin
    index_out = 5'h00;
    found_out = |vec_m;
    if (SCAN_DOWN) begin
      for (int i = 0; i < 32; i++) begin
        if (vec_m[i]) begin
          index_out = 5'(i);
        end
      end
    end else begin
      for (int i = 31; i >= 0; i--) begin
        if (vec_m[i]) begin
          index_out = 5'(i);
        end
      end
    end
  end

endmodule // bmu_bit_scan

/* bmu_bit_manipulation_unit.sv */
// Bit manipulation datapath with its register port
// Overview of operation
// RULE_01 - Left double shift moves destination up, fills low bits from source
// RULE_02 - Double shift operands share one width, 16 or 32 bits
// RULE_03 - Double shift count spans 0 through 31
// RULE_04 - Double shift writes destination only; source stays unchanged
// RULE_05 - After double shift, carry holds last bit shifted out of destination
// RULE_06 - Right double shift follows same operand, count and carry behaviour
// RULE_07 - Right double shift moves destination down, source enters at top
// RULE_08 - Rotates recirculate exiting bits, count 0 to 31
// RULE_09 - Plain left rotate goes upward, plain right rotate goes downward
// RULE_10 - Left rotate via carry: top bit into carry, old carry into bit 0
// RULE_11 - Right rotate via carry shifts down with carry inside the ring
// RULE_12 - Every rotate leaves carry equal to the last bit rotated out
// RULE_13 - Bit probes copy selected bit into carry before modifying it
// RULE_14 - Probe keeps bit, force one sets, force zero clears, invert flips
// RULE_15 - Upward scan returns index of lowest set bit
// RULE_16 - Downward scan returns index of highest set bit
// RULE_17 - Scan of all-zero source raises a no-bit-found indication
// RULE_18 - Set byte writes exactly 0 or 1 from the encoded flag condition
// RULE_19 - Overflow condition gives 1 when overflow set, 0 when clear
// RULE_20 - And test updates sign, zero and parity from the AND result
// RULE_21 - And test discards the result and alters neither operand
// RULE_22 - Zero-count shift or rotate changes neither destination nor flags
`timescale 1ns/1ps
module bmu_bit_manipulation_unit
  import bmu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic [4:0] flags_out,
  output logic no_bit_found_out
);

  bmu_state_t st_q;
  bmu_state_t st_d;

  logic ctrl_wr;
  bmu_op_t op_w;
  logic wide_w;
  logic [4:0] cnt_w;
  logic [3:0] cc_w;
  logic [4:0] up_idx;
  logic up_found;
  logic [4:0] dn_idx;
  logic dn_found;

  // Results of the operation selected by a control write
  logic [31:0] x_dest;
  logic x_c;
  logic x_o;
  logic x_s;
  logic x_z;
  logic x_p;
  logic x_nbf;

  // Helpers that the checks read
  logic [4:0] probe_idx;
  logic [31:0] bit_mask;
  logic sel_bit;
  logic and_zero;
  logic src_zero;

  assign ctrl_wr = wr_in && (addr_in == BMU_OFF_CTRL);
  assign op_w = bmu_op_t'(wdata_in[BMU_CTRL_OP_LSB +: BMU_CTRL_OP_W]);
  assign wide_w = wdata_in[BMU_CTRL_WIDE_BIT];
  assign cnt_w = wdata_in[BMU_CTRL_CNT_LSB +: BMU_CTRL_CNT_W];
  assign cc_w = wdata_in[BMU_CTRL_CC_LSB +: BMU_CTRL_CC_W];

  // Bit offset wraps at the operand width
  assign probe_idx = wide_w ? cnt_w : {1'b0, cnt_w[3:0]}; // RULE_13
  assign bit_mask = 32'h0000_0001 << probe_idx;
  assign sel_bit = st_q.dest[probe_idx];
  assign and_zero = wide_w ? ((st_q.dest & st_q.src) == 32'h0)
                           : ((st_q.dest[15:0] & st_q.src[15:0]) == 16'h0);
  assign src_zero = wide_w ? (st_q.src == 32'h0) : (st_q.src[15:0] == 16'h0);

  // Scanners over the source operand
  bmu_bit_scan #(
    .SCAN_DOWN(1'b0)
  ) u_scan_up (
    .vec_in(st_q.src),
    .wide_in(wide_w),
    .index_out(up_idx),
    .found_out(up_found)
  ); // RULE_15

  bmu_bit_scan #(
    .SCAN_DOWN(1'b1)
  ) u_scan_dn (
    .vec_in(st_q.src),
    .wide_in(wide_w),
    .index_out(dn_idx),
    .found_out(dn_found)
  ); // RULE_16

  // Datapath for the operation in the incoming control word
  always_comb begin
    logic [63:0] cat;
    logic [63:0] sh;
    logic [31:0] ring;
    logic ring_c;
    logic ring_n;
    logic [31:0] res;
    logic [3:0] n4;
    logic [6:0] pos;
    logic cond;
    logic upd_szp;
    cat = 64'h0;
    sh = 64'h0;
    ring = st_q.dest;
    ring_c = st_q.carry_flag;
    ring_n = 1'b0;
    res = st_q.dest;
    n4 = cnt_w[3:0];
    pos = 7'h00;
    cond = 1'b0;
    upd_szp = 1'b0;
    x_c = st_q.carry_flag;
    x_o = st_q.overflow_flag;
    x_nbf = st_q.no_bit_found;
    case (op_w)
      BMU_OP_DOUBLE_SHIFT_LEFT: begin
        // Destination on top, source bits follow into the gap
        cat = wide_w ? {st_q.dest, st_q.src}
                     : {st_q.dest[15:0], st_q.src[15:0], 32'h0}; // RULE_02
        sh = cat << cnt_w; // RULE_01 RULE_03
        res = wide_w ? sh[63:32] : {st_q.dest[31:16], sh[63:48]};
        pos = 7'd64 - {2'b00, cnt_w};
        if (cnt_w != 5'h00) begin // RULE_22
          x_c = cat[pos[5:0]]; // RULE_05
          upd_szp = 1'b1;
        end
      end
      BMU_OP_DOUBLE_SHIFT_RIGHT: begin
        // Source sits above destination and enters from the top
        cat = wide_w ? {st_q.src, st_q.dest}
                     : {32'h0, st_q.src[15:0], st_q.dest[15:0]}; // RULE_06
        sh = cat >> cnt_w; // RULE_07
        res = wide_w ? sh[31:0] : {st_q.dest[31:16], sh[15:0]};
        pos = {2'b00, cnt_w} - 7'd1;
        if (cnt_w != 5'h00) begin
          x_c = cat[pos[5:0]]; // RULE_05 RULE_06
          upd_szp = 1'b1;
        end
      end
      BMU_OP_ROTATE_LEFT_PLAIN: begin
        if (wide_w) begin
          sh = {st_q.dest, st_q.dest} << cnt_w; // RULE_08 RULE_09
          res = sh[63:32];
        end else begin
          sh = {32'h0, st_q.dest[15:0], st_q.dest[15:0]} << n4;
          res = {st_q.dest[31:16], sh[31:16]};
        end
        if (cnt_w != 5'h00) begin
          x_c = res[0]; // RULE_12
        end
      end
      BMU_OP_ROTATE_RIGHT_PLAIN: begin
        if (wide_w) begin
          sh = {st_q.dest, st_q.dest} >> cnt_w; // RULE_08 RULE_09
          res = sh[31:0];
        end else begin
          sh = {32'h0, st_q.dest[15:0], st_q.dest[15:0]} >> n4;
          res = {st_q.dest[31:16], sh[15:0]};
        end
        if (cnt_w != 5'h00) begin
          x_c = wide_w ? res[31] : res[15]; // RULE_12
        end
      end
      BMU_OP_ROTATE_LEFT_VIA_CARRY: begin
        // One step per count; carry is the bit above the operand
        for (int i = 0; i < 31; i++) begin
          if (5'(i) < cnt_w) begin
            ring_n = wide_w ? ring[31] : ring[15]; // RULE_10
            ring = {ring[30:0], ring_c};
            ring_c = ring_n;
          end
        end
        res = wide_w ? ring : {st_q.dest[31:16], ring[15:0]};
        x_c = ring_c; // RULE_12
      end
      BMU_OP_ROTATE_RIGHT_VIA_CARRY: begin
        // Old carry enters at the top, bit 0 leaves into carry
        for (int i = 0; i < 31; i++) begin
          if (5'(i) < cnt_w) begin
            ring_n = ring[0]; // RULE_11
            ring = {1'b0, ring[31:1]};
            if (wide_w) begin
              ring[31] = ring_c;
            end else begin
              ring[15] = ring_c;
            end
            ring_c = ring_n;
          end
        end
        res = wide_w ? ring : {st_q.dest[31:16], ring[15:0]};
        x_c = ring_c; // RULE_12
      end
      BMU_OP_BIT_PROBE: begin
        x_c = sel_bit; // RULE_13 RULE_14
      end
      BMU_OP_BIT_PROBE_AND_FORCE_ONE: begin
        x_c = sel_bit; // RULE_13
        res = st_q.dest | bit_mask; // RULE_14
      end
      BMU_OP_BIT_PROBE_AND_FORCE_ZERO: begin
        x_c = sel_bit; // RULE_13
        res = st_q.dest & ~bit_mask; // RULE_14
      end
      BMU_OP_BIT_PROBE_AND_INVERT: begin
        x_c = sel_bit; // RULE_13
        res = st_q.dest ^ bit_mask; // RULE_14
      end
      BMU_OP_SCAN_UP_FIRST_ONE: begin
        x_nbf = !up_found; // RULE_17
        if (up_found) begin
          res = {27'h0, up_idx}; // RULE_15
        end
      end
      BMU_OP_SCAN_DOWN_FIRST_ONE: begin
        x_nbf = !dn_found; // RULE_17
        if (dn_found) begin
          res = {27'h0, dn_idx}; // RULE_16
        end
      end
      BMU_OP_SET_BYTE_ON_CONDITION: begin
        case (cc_w[3:1])
          BMU_CC_OVERFLOW: cond = st_q.overflow_flag; // RULE_19
          BMU_CC_CARRY: cond = st_q.carry_flag;
          BMU_CC_ZERO: cond = st_q.zero_flag;
          BMU_CC_CARRY_OR_ZERO: cond = st_q.carry_flag | st_q.zero_flag;
          BMU_CC_SIGN: cond = st_q.sign_flag;
          BMU_CC_PARITY: cond = st_q.parity_flag;
          BMU_CC_LESS: cond = st_q.sign_flag ^ st_q.overflow_flag;
          BMU_CC_LESS_EQUAL: begin
            cond = (st_q.sign_flag ^ st_q.overflow_flag) | st_q.zero_flag;
          end
          default: cond = 1'b0;
        endcase
        res = {st_q.dest[31:8], 7'h00, cond ^ cc_w[0]}; // RULE_18
      end
      BMU_OP_AND_TEST: begin
        // Flags from the AND; destination keeps its value
        res = st_q.dest & st_q.src; // RULE_20
        x_c = 1'b0;
        x_o = 1'b0;
        upd_szp = 1'b1;
      end
      default: begin
        res = st_q.dest;
      end
    endcase
    // Sign and zero of the operand-width result, parity of its low byte
    x_s = st_q.sign_flag;
    x_z = st_q.zero_flag;
    x_p = st_q.parity_flag;
    if (op_w == BMU_OP_SCAN_UP_FIRST_ONE ||
        op_w == BMU_OP_SCAN_DOWN_FIRST_ONE) begin
      x_z = x_nbf;
    end
    if (upd_szp) begin
      x_s = wide_w ? res[31] : res[15];
      x_z = wide_w ? (res == 32'h0) : (res[15:0] == 16'h0);
      x_p = ~^res[7:0];
    end
    // And test throws its result away
    x_dest = (op_w == BMU_OP_AND_TEST) ? st_q.dest : res; // RULE_21
  end

  // Next state: register writes, execution and read data
  always_comb begin
    st_d = st_q;
    st_d.rdata = 32'h0;
    if (rd_in) begin
      if (addr_in == BMU_OFF_DEST) begin
        st_d.rdata = st_q.dest;
      end else if (addr_in == BMU_OFF_SRC) begin
        st_d.rdata = st_q.src;
      end else if (addr_in == BMU_OFF_CTRL) begin
        st_d.rdata = st_q.ctrl;
      end else if (addr_in == BMU_OFF_FLAGS) begin
        st_d.rdata[BMU_FLG_CARRY] = st_q.carry_flag;
        st_d.rdata[BMU_FLG_OVERFLOW] = st_q.overflow_flag;
        st_d.rdata[BMU_FLG_SIGN] = st_q.sign_flag;
        st_d.rdata[BMU_FLG_ZERO] = st_q.zero_flag;
        st_d.rdata[BMU_FLG_PARITY] = st_q.parity_flag;
      end else if (addr_in == BMU_OFF_STATUS) begin
        st_d.rdata[BMU_STS_NO_BIT] = st_q.no_bit_found;
      end else begin
        st_d.rdata = 32'h0;
      end
    end
    if (wr_in) begin
      if (addr_in == BMU_OFF_DEST) begin
        st_d.dest = wdata_in;
      end else if (addr_in == BMU_OFF_SRC) begin
        st_d.src = wdata_in;
      end else if (addr_in == BMU_OFF_FLAGS) begin
        st_d.carry_flag = wdata_in[BMU_FLG_CARRY];
        st_d.overflow_flag = wdata_in[BMU_FLG_OVERFLOW];
        st_d.sign_flag = wdata_in[BMU_FLG_SIGN];
        st_d.zero_flag = wdata_in[BMU_FLG_ZERO];
        st_d.parity_flag = wdata_in[BMU_FLG_PARITY];
      end else if (addr_in == BMU_OFF_CTRL) begin
        // Only the destination, flags and no-bit-found status take the outcome
        st_d.ctrl = wdata_in;
        st_d.dest = x_dest; // RULE_04
        st_d.carry_flag = x_c;
        st_d.overflow_flag = x_o;
        st_d.sign_flag = x_s;
        st_d.zero_flag = x_z;
        st_d.parity_flag = x_p;
        st_d.no_bit_found = x_nbf;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_q <= '{dest: BMU_RST_WORD, src: BMU_RST_WORD, ctrl: BMU_RST_WORD,
                carry_flag: BMU_RST_FLAG, overflow_flag: BMU_RST_FLAG,
                sign_flag: BMU_RST_FLAG, zero_flag: BMU_RST_FLAG,
                parity_flag: BMU_RST_FLAG, no_bit_found: BMU_RST_FLAG,
                rdata: BMU_RST_WORD};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign rdata_out = st_q.rdata;
  assign flags_out = {st_q.parity_flag, st_q.zero_flag, st_q.sign_flag,
                      st_q.overflow_flag, st_q.carry_flag};
  assign no_bit_found_out = st_q.no_bit_found;

  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic is_shift_rot;
  logic msb_now;
  assign is_shift_rot = (op_w == BMU_OP_DOUBLE_SHIFT_LEFT) ||
                        (op_w == BMU_OP_DOUBLE_SHIFT_RIGHT) ||
                        (op_w == BMU_OP_ROTATE_LEFT_PLAIN) ||
                        (op_w == BMU_OP_ROTATE_RIGHT_PLAIN) ||
                        (op_w == BMU_OP_ROTATE_LEFT_VIA_CARRY) ||
                        (op_w == BMU_OP_ROTATE_RIGHT_VIA_CARRY);
  assign msb_now = st_q.dest[31];

  AST_SRC_KEPT: assert property ( // RULE_04
    ctrl_wr |=> st_q.src == $past(st_q.src)
  ) else $error("source changed by an operation");

  AST_ZERO_COUNT: assert property ( // RULE_22
    ctrl_wr && is_shift_rot && cnt_w == 5'h00
    |=> st_q.dest == $past(st_q.dest) && flags_out == $past(flags_out)
  ) else $error("zero count altered destination or flags");

  AST_PROBE_CARRY: assert property ( // RULE_13
    ctrl_wr && op_w inside {BMU_OP_BIT_PROBE, BMU_OP_BIT_PROBE_AND_INVERT}
    |=> st_q.carry_flag == $past(sel_bit)
  ) else $error("carry does not hold the old selected bit");

  AST_FORCE_ONE: assert property ( // RULE_14
    ctrl_wr && op_w == BMU_OP_BIT_PROBE_AND_FORCE_ONE
    |=> st_q.dest == ($past(st_q.dest) | $past(bit_mask))
  ) else $error("force one did not set only the selected bit");

  AST_BYTE_BINARY: assert property ( // RULE_18
    ctrl_wr && op_w == BMU_OP_SET_BYTE_ON_CONDITION
    |=> st_q.dest[7:1] == 7'h00
  ) else $error("set byte wrote a value other than 0 or 1");

  AST_BYTE_OVERFLOW: assert property ( // RULE_19
    ctrl_wr && op_w == BMU_OP_SET_BYTE_ON_CONDITION && cc_w == 4'h0
    |=> st_q.dest[0] == $past(st_q.overflow_flag)
  ) else $error("overflow condition byte wrong");

  AST_TEST_KEEPS: assert property ( // RULE_21
    ctrl_wr && op_w == BMU_OP_AND_TEST
    |=> st_q.dest == $past(st_q.dest) && st_q.src == $past(st_q.src)
  ) else $error("and test altered an operand");

  AST_TEST_ZERO: assert property ( // RULE_20
    ctrl_wr && op_w == BMU_OP_AND_TEST
    |=> st_q.zero_flag == $past(and_zero)
  ) else $error("and test zero flag wrong");

  AST_SCAN_EMPTY: assert property ( // RULE_17
    ctrl_wr && src_zero && op_w inside {BMU_OP_SCAN_UP_FIRST_ONE,
                                        BMU_OP_SCAN_DOWN_FIRST_ONE}
    |=> no_bit_found_out && st_q.dest == $past(st_q.dest)
  ) else $error("empty scan not flagged");

  AST_RING_LEFT_ONE: assert property ( // RULE_10
    ctrl_wr && op_w == BMU_OP_ROTATE_LEFT_VIA_CARRY && wide_w &&
    cnt_w == 5'h01
    |=> st_q.carry_flag == $past(msb_now) &&
        st_q.dest[0] == $past(st_q.carry_flag)
  ) else $error("rotate via carry by one wrong");

  COV_DSHL: cover property (
    ctrl_wr && op_w == BMU_OP_DOUBLE_SHIFT_LEFT && cnt_w != 5'h00);
  COV_RING_RIGHT: cover property (
    ctrl_wr && op_w == BMU_OP_ROTATE_RIGHT_VIA_CARRY && cnt_w == 5'h1f);
  COV_SCAN_EMPTY: cover property (ctrl_wr && src_zero &&
    op_w == BMU_OP_SCAN_DOWN_FIRST_ONE);
  COV_READ_BACK: cover property (ctrl_wr ##1 rd_in);

endmodule // bmu_bit_manipulation_unit

/* bmu_bit_manipulation_unit_tb_top.sv */
// Self-checking testbench of the bit manipulation unit
`timescale 1ns/1ps
module bmu_bit_manipulation_unit_tb_top
  import bmu_pkg::*;
;
  logic sys_clk_in;
  logic rst_n_in;
  logic [7:0] addr_in;
  logic [31:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [31:0] rdata_out;
  logic [4:0] flags_out;
  logic no_bit_found_out;
  int error_cnt = 0;
  int tests_run = 0;
  logic rd_seen = 1'b0;
  logic [31:0] rng = 32'h0000_0014;
  logic [31:0] exp_q[$];
  string nm_q[$];
  logic [31:0] m_dest;
  logic [31:0] m_src;
  logic [4:0] m_flg;
  logic m_nb = 1'b0;

  bmu_bit_manipulation_unit uut (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .flags_out(flags_out),
    .no_bit_found_out(no_bit_found_out)
  );

  // 200 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  // Pseudo-random source
  function automatic logic [31:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus cycle; reads note their expected data
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] e, input string nm);
    @(posedge sys_clk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    if (!w) begin
      exp_q.push_back(e);
      nm_q.push_back(nm);
    end
  endtask

  task automatic idle();
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
  endtask

  // Read data watcher, one cycle after each read strobe
  always @(posedge sys_clk_in) begin
    if (rd_seen) begin
      chk(nm_q.pop_front(), rdata_out, exp_q.pop_front());
    end else if (rst_n_in) begin
      chk("idle_rdata", rdata_out, 32'h0);
    end
    rd_seen <= rd_in;
  end

  // Reference behaviour of one operation
  task automatic model(input logic [3:0] op, input logic w,
      input logic [4:0] c, input logic [3:0] cc);
    int n;
    logic [31:0] d;
    logic [31:0] s;
    logic [31:0] mk;
    logic cy;
    logic t;
    logic [7:0] cv;
    logic [4:0] f;
    n = w ? 32 : 16;
    mk = w ? 32'hffff_ffff : 32'h0000_ffff;
    d = m_dest & mk;
    s = m_src & mk;
    f = m_flg;
    cy = f[0];
    cv = {(f[2] ^ f[1]) | f[3], f[2] ^ f[1], f[4], f[2], f[0] | f[3],
          f[3], f[0], f[1]};
    if (op < 4'h6) begin
      for (int i = 0; i < c; i++) begin
        if (op[0]) begin
          t = d[0];
          d = (d >> 1) | ((op == 4'h1 ? s[0] : op == 4'h3 ? t : cy) ?
              32'h1 << (n - 1) : 32'h0);
          s = s >> 1;
        end else begin
          t = d[n - 1];
          d = ((d << 1) | (op == 4'h0 ? s[n - 1] : op == 4'h2 ? t : cy))
              & mk;
          s = (s << 1) & mk;
        end
        cy = t;
      end
      f[0] = cy;
      if (op < 4'h2 && c != 5'h00) begin
        f[2] = d[n - 1];
        f[3] = (d == 32'h0);
        f[4] = ~^d[7:0];
      end
    end else if (op < 4'ha) begin
      f[0] = d[c % n];
      case (op)
        4'h7: d[c % n] = 1'b1;
        4'h8: d[c % n] = 1'b0;
        4'h9: d[c % n] = ~d[c % n];
        default: ;
      endcase
    end else if (op < 4'hc) begin
      t = 1'b0;
      for (int i = 0; i < n; i++) begin
        if (s[op[0] ? n - 1 - i : i] && !t) begin
          d = 32'(op[0] ? n - 1 - i : i);
          t = 1'b1;
          m_dest[31:16] = 16'h0;
        end
      end
      m_nb = !t;
      f[3] = !t;
    end else if (op == 4'hc) begin
      d[7:0] = {7'h00, cv[cc[3:1]] ^ cc[0]};
    end else if (op == 4'hd) begin
      s = d & s;
      f[1:0] = 2'b00;
      f[2] = s[n - 1];
      f[3] = (s == 32'h0);
      f[4] = ~^s[7:0];
    end
    m_flg = f;
    m_dest = w ? d : {m_dest[31:16], d[15:0]};
  endtask

  // Load operands, execute, read back operands, flags and, after scans, scan status
  task automatic run_op(input logic [31:0] d, input logic [31:0] s,
      input logic [4:0] f, input logic [3:0] op, input logic w,
      input logic [4:0] c, input logic [3:0] cc);
    m_dest = d;
    m_src = s;
    m_flg = f;
    bus(1'b1, BMU_OFF_DEST, d, 32'h0, "");
    bus(1'b1, BMU_OFF_SRC, s, 32'h0, "");
    bus(1'b1, BMU_OFF_FLAGS, {27'h0, f}, 32'h0, "");
    model(op, w, c, cc);
    bus(1'b1, BMU_OFF_CTRL, {12'h000, cc, 3'h0, c, 3'h0, w, op}, 32'h0, "");
    bus(1'b0, BMU_OFF_DEST, 32'h0, m_dest, "dest");
    #1;
    chk("flags_out", {27'h0, flags_out}, {27'h0, m_flg});
    if (op == 4'ha || op == 4'hb) begin
      chk("no_bit", {31'h0, no_bit_found_out}, {31'h0, m_nb});
      bus(1'b0, BMU_OFF_STATUS, 32'h0, {31'h0, m_nb}, "status");
    end
    bus(1'b0, BMU_OFF_SRC, 32'h0, m_src, "src");
    bus(1'b0, BMU_OFF_FLAGS, 32'h0, {27'h0, m_flg}, "flags");
    idle();
  endtask

  // Run summary and verdict
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [31:0] s;
    logic [31:0] r;
    logic w;
    logic [4:0] c;
    rst_n_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    // Reset values, unmapped and read-only places
    for (int a = 0; a < 6; a++) begin
      bus(1'b0, 8'(a * 4), 32'h0, 32'h0, "reset_reg");
    end
    bus(1'b1, 8'h14, 32'hffff_ffff, 32'h0, "");
    bus(1'b1, BMU_OFF_STATUS, 32'h0000_0001, 32'h0, "");
    bus(1'b0, BMU_OFF_STATUS, 32'h0, 32'h0, "status_ro");
    bus(1'b0, 8'hfc, 32'h0, 32'h0, "unmapped");
    idle();
    chk("flags_rst", {27'h0, flags_out}, 32'h0);
    $display("test reset done");
    // Every operation code, with count and operand corner cases
    for (int op = 0; op < 16; op++) begin
      for (int k = 0; k < 10; k++) begin
        d = nxt();
        s = nxt();
        r = nxt();
        w = r[0] | (k == 1);
        c = r[12:8];
        if (k == 0) c = 5'h00;
        if (k == 1) c = 5'h1f;
        if (k == 2) s = 32'h0;
        if (k == 3) begin
          s = 32'h0001_0000;
          w = 1'b0;
        end
        if (op < 2 && !w && c > 5'h10) c = 5'h10;
        run_op(d, s, r[20:16], 4'(op), w, c, r[27:24]);
      end
    end
    $display("test ops done");
    // Every condition code of set byte
    for (int cc = 0; cc < 16; cc++) begin
      r = nxt();
      run_op(nxt(), nxt(), r[4:0], 4'hc, r[5], 5'h00, 4'(cc));
      run_op(nxt(), nxt(), ~r[4:0], 4'hc, r[6], 5'h00, 4'(cc));
    end
    $display("test cond done");
    repeat (3) @(posedge sys_clk_in);
    chk("queue_left", 32'(exp_q.size()), 32'h0);
    give_verdict();
  end
endmodule // bmu_bit_manipulation_unit_tb_top
